// ==== logic/smr_pkg.sv ====
/*
 * Package for the stop mode and reset control block: register offsets,
 * field positions, reset values, timing constants, states and flag carrier.
 * Assumes a 100 MHz system clock feeding the block.
 */
`default_nettype none

package smr_pkg;

	// =====================================================
	// register offsets on the special function register port
	localparam logic [7:0] SMR_PWR_CTRL_ADDR = 8'h87;
	localparam logic [7:0] SMR_RST_SRC_ADDR = 8'hEF;
	localparam logic [7:0] SMR_SUP_MON_ADDR = 8'hFF;

	// =====================================================
	// field positions
	localparam int SMR_PC_IDLE_BIT = 0;
	localparam int SMR_PC_STOP_BIT = 1;
	localparam int SMR_PC_GF_LO = 2;
	localparam int SMR_RS_PIN_BIT = 0;
	localparam int SMR_RS_POR_BIT = 1;
	localparam int SMR_RS_MCD_BIT = 2;
	localparam int SMR_SM_EN_BIT = 7;
	localparam int SMR_SM_OK_BIT = 6;

	// =====================================================
	// reset values
	localparam logic [7:0] SMR_PWR_CTRL_RST = 8'h00;
	localparam logic [7:0] SMR_PORT_LATCH_RST = 8'hFF;
	localparam logic [15:0] SMR_RESET_VECTOR = 16'h0000;

	// =====================================================
	// timing
	localparam int SMR_CLK_PERIOD_NS = 10;
	localparam int SMR_POR_DELAY_NS = 300000;
	localparam int SMR_MCD_TIMEOUT_NS = 100000;
	// longest time: round down
	localparam int SMR_POR_CYC = SMR_POR_DELAY_NS / SMR_CLK_PERIOD_NS;
	// least time: round up
	localparam int SMR_MCD_CYC = (SMR_MCD_TIMEOUT_NS + SMR_CLK_PERIOD_NS - 1) / SMR_CLK_PERIOD_NS;
	localparam logic [3:0] SMR_WDT_DIV_LAST = 4'hb;

	// =====================================================
	// types
	typedef enum logic [1:0] {ST_SUPPLY, ST_POR_DLY, ST_HOLD, ST_RUN} smr_state_e;

	typedef struct packed {
		logic lost_clock_detector;
		logic por;
		logic pin;
	} smr_rst_flags_s;

endpackage

`default_nettype wire

// ==== logic/smr_top.sv ====
/*
 * Stop mode and reset sequencing for an 8-bit controller core.
 * Assumes all inputs synchronous to clk_sys_in, rst_in is the power-up
 * reset, core_tick_in pulses once per core clock edge seen by the monitor.
 */
`default_nettype none

module smr_top
	import smr_pkg::*;
#(
	parameter int unsigned POR_CYC = SMR_POR_CYC,
	parameter int unsigned MCD_CYC = SMR_MCD_CYC
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	input wire logic supply_ok_in,
	input wire logic ext_rst_n_in,
	input wire logic core_tick_in,
	input wire logic irq_wake_in,
	input wire logic wdt_disable_in,
	output logic rst_pin_out,
	output logic rst_pin_oe_out,
	output logic sys_reset_out,
	output logic cpu_run_out,
	output logic int_osc_run_out,
	output logic periph_run_out,
	output logic idle_out,
	output logic pc_load_out,
	output logic [15:0] pc_vector_out,
	output logic clk_sel_int_out,
	output logic wdt_enable_out,
	output logic wdt_tick_out,
	output logic [7:0] port_latch_out,
	output logic port_od_force_out,
	output logic pullup_en_out
);

	// =====================================================
	// state and registers
	smr_state_e state_r, state_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [15:0] mcd_cnt_r;
	logic [5:0] gflags_r;
	logic stop_r, idle_r;
	logic mcd_en_r, vdm_en_r;
	logic vdm_cause_r, pin_cause_r, mcd_cause_r;
	smr_rst_flags_s flags_r;
	logic [3:0] wdt_div_r;
	logic wdt_en_r;
	logic [7:0] rdata_r;
	logic pc_load_r;

	// =====================================================
	// decode
	wire running = state_r == ST_RUN;
	wire wr_pc = sfr_wr_in && running && sfr_addr_in == SMR_PWR_CTRL_ADDR;
	wire wr_rs = sfr_wr_in && running && sfr_addr_in == SMR_RST_SRC_ADDR;
	wire wr_sm = sfr_wr_in && running && sfr_addr_in == SMR_SUP_MON_ADDR;
	wire sw_por = wr_rs && sfr_wdata_in[SMR_RS_PIN_BIT];
	// selecting the monitor while it is off is a reset in itself
	wire sel_fault = wr_rs && sfr_wdata_in[SMR_RS_POR_BIT] && !vdm_en_r;
	wire vdm_fail = vdm_en_r && !supply_ok_in;
	wire pin_low = !ext_rst_n_in;
	wire mcd_fire = mcd_en_r && running && mcd_cnt_r >= MCD_CYC[15:0] - 16'h0001;
	wire other_rst = vdm_fail || pin_low || mcd_fire || sel_fault;
	wire hold_done = !pin_low && !vdm_fail;

	// =====================================================
	// reset sequencer
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		unique case (state_r)
			ST_SUPPLY: begin
				cnt_nxt = 16'h0000;
				if (supply_ok_in) begin
					state_nxt = ST_POR_DLY;
				end
			end
			ST_POR_DLY: begin
				cnt_nxt = cnt_r + 16'h0001;
				if (!supply_ok_in) begin
					state_nxt = ST_SUPPLY;
				end else if (cnt_r >= POR_CYC[15:0] - 16'h0001) begin
					state_nxt = ST_RUN;
				end
			end
			ST_HOLD: begin
				if (hold_done) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (sw_por) begin
					state_nxt = ST_SUPPLY;
				end else if (other_rst) begin
					state_nxt = ST_HOLD;
				end
			end
		endcase
	end

	wire enter_hold = running && !sw_por && other_rst;
	wire leave_rst = !running && state_nxt == ST_RUN;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state_r <= ST_SUPPLY;
			cnt_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// causes of the current hold, kept to pick flags and the pin drive
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || state_r == ST_SUPPLY) begin
			vdm_cause_r <= 1'b0;
			pin_cause_r <= 1'b0;
			mcd_cause_r <= 1'b0;
		end else if (enter_hold) begin
			vdm_cause_r <= vdm_fail;
			pin_cause_r <= pin_low;
			mcd_cause_r <= mcd_fire;
		end else if (state_r == ST_HOLD) begin
			vdm_cause_r <= vdm_cause_r || vdm_fail;
			pin_cause_r <= pin_cause_r || pin_low;
		end
	end

	// =====================================================
	// reset source flags; other flags of a power-on exit are left zero
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			flags_r <= '0;
		end else if (leave_rst) begin
			flags_r.por <= state_r == ST_POR_DLY;
			flags_r.pin <= state_r == ST_HOLD && pin_cause_r;
			flags_r.lost_clock_detector <= state_r == ST_HOLD && mcd_cause_r;
		end
	end

	// supply monitor: on after power-on, other resets leave it alone
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || state_r == ST_POR_DLY) begin
			vdm_en_r <= 1'b1;
		end else if (wr_sm) begin
			vdm_en_r <= sfr_wdata_in[SMR_SM_EN_BIT];
		end
	end

	// =====================================================
	// software registers; every reset returns them to reset values
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || !running) begin
			gflags_r <= SMR_PWR_CTRL_RST[7:2];
			stop_r <= SMR_PWR_CTRL_RST[SMR_PC_STOP_BIT];
			idle_r <= SMR_PWR_CTRL_RST[SMR_PC_IDLE_BIT];
			mcd_en_r <= 1'b0;
		end else begin
			if (wr_pc) begin
				gflags_r <= sfr_wdata_in[7:SMR_PC_GF_LO];
			end
			// only a reset clears stop
			if (wr_pc && sfr_wdata_in[SMR_PC_STOP_BIT]) begin
				stop_r <= 1'b1;
			end
			if (wr_pc) begin
				idle_r <= sfr_wdata_in[SMR_PC_IDLE_BIT];
			end else if (irq_wake_in) begin
				idle_r <= 1'b0;
			end
			if (wr_rs) begin
				mcd_en_r <= sfr_wdata_in[SMR_RS_MCD_BIT];
			end
		end
	end

	// =====================================================
	// missing clock one-shot; core ticks vanish while stopped
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || !mcd_en_r || core_tick_in) begin
			mcd_cnt_r <= 16'h0000;
		end else if (!mcd_fire) begin
			mcd_cnt_r <= mcd_cnt_r + 16'h0001;
		end
	end

	// =====================================================
	// watchdog clock, divide by twelve
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || !running) begin
			wdt_en_r <= 1'b1;
			wdt_div_r <= 4'h0;
		end else begin
			if (wdt_disable_in) begin
				wdt_en_r <= 1'b0;
			end
			if (!stop_r) begin
				wdt_div_r <= wdt_div_r == SMR_WDT_DIV_LAST ? 4'h0 : wdt_div_r + 4'h1;
			end
		end
	end

	// =====================================================
	// read port
	wire [7:0] rd_pc = {gflags_r, 1'b0, idle_r};
	wire [7:0] rd_rs = {5'h00, flags_r.lost_clock_detector, flags_r.por, flags_r.pin};
	wire [7:0] rd_sm = {vdm_en_r, supply_ok_in, 6'h00};
	wire [7:0] rd_mux = sfr_addr_in == SMR_PWR_CTRL_ADDR ? rd_pc :
		sfr_addr_in == SMR_RST_SRC_ADDR ? rd_rs :
		sfr_addr_in == SMR_SUP_MON_ADDR ? rd_sm : 8'h00;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rdata_r <= 8'h00;
			pc_load_r <= 1'b0;
		end else begin
			rdata_r <= sfr_rd_in ? rd_mux : rdata_r;
			pc_load_r <= leave_rst;
		end
	end

	// =====================================================
	// outputs
	// pin is driven only for power-on and supply-monitor resets
	wire drive_pin = state_r == ST_SUPPLY || state_r == ST_POR_DLY ||
		(state_r == ST_HOLD && vdm_cause_r);
	assign rst_pin_oe_out = drive_pin;
	assign rst_pin_out = 1'b0;
	assign sys_reset_out = !running;
	assign cpu_run_out = running && !stop_r && !idle_r;
	// oscillator runs from the second cycle of reset on, once stop_r has cleared, so the sequencer keeps its clock
	assign int_osc_run_out = !stop_r;
	assign periph_run_out = !stop_r;
	assign idle_out = idle_r;
	assign pc_load_out = pc_load_r;
	assign pc_vector_out = SMR_RESET_VECTOR;
	assign clk_sel_int_out = !running;
	assign wdt_enable_out = wdt_en_r;
	assign wdt_tick_out = wdt_en_r && running && !stop_r && wdt_div_r == SMR_WDT_DIV_LAST;
	assign port_latch_out = running ? 8'h00 : SMR_PORT_LATCH_RST;
	assign port_od_force_out = !running;
	assign pullup_en_out = 1'b1;
	assign sfr_rdata_out = rdata_r;

	// =====================================================
	// checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	sequence stop_write_s;
		wr_pc && sfr_wdata_in[SMR_PC_STOP_BIT] && !other_rst;
	endsequence

	sequence por_exit_s;
		state_r == ST_POR_DLY ##1 state_r == ST_RUN;
	endsequence

	stop_entry_a: assert property (stop_write_s |=> stop_r && !cpu_run_out)
		else $error("stop not entered after stop write");
	stop_halt_a: assert property (stop_r |-> !int_osc_run_out && !periph_run_out)
		else $error("clocks running in stop");
	stop_exit_a: assert property (stop_r && running && !other_rst && !sw_por |=> stop_r)
		else $error("stop left without reset");
	mcd_reset_a: assert property (mcd_fire |=> sys_reset_out && !rst_pin_oe_out)
		else $error("missing clock did not reset");
	gflag_store_a: assert property (wr_pc && !other_rst ##1 sfr_rd_in && sfr_addr_in == SMR_PWR_CTRL_ADDR
		|=> sfr_rdata_out[7:2] == $past(sfr_wdata_in[7:2], 2))
		else $error("general flags not stored");
	stop_read_a: assert property (sfr_rd_in && sfr_addr_in == SMR_PWR_CTRL_ADDR |=> !sfr_rdata_out[1])
		else $error("stop bit read as one");
	pin_drive_a: assert property (state_r == ST_POR_DLY |-> rst_pin_oe_out && !rst_pin_out)
		else $error("reset pin not driven in power-on reset");
	por_delay_a: assert property ($rose(state_r == ST_POR_DLY) && supply_ok_in ##1 supply_ok_in[*7]
		|-> state_r == ST_POR_DLY)
		else $error("power-on delay too short");
	exit_load_a: assert property ($fell(sys_reset_out) |-> pc_load_out && wdt_enable_out)
		else $error("reset exit without load");
	por_flag_a: assert property (por_exit_s |-> flags_r.por && !flags_r.pin)
		else $error("power-on flag wrong");
	vdm_keep_a: assert property (enter_hold |=> vdm_en_r == $past(vdm_en_r))
		else $error("monitor setting changed by reset");
	swpor_a: assert property (sw_por |=> state_r == ST_SUPPLY ##1 state_r != ST_RUN)
		else $error("software power-on reset missing");
	idle_set_a: assert property (wr_pc && sfr_wdata_in[0] && !other_rst |=> idle_out)
		else $error("idle not entered");

	// reset exits are judged one edge later, once the flags have landed
	sequence hold_exit_s;
		state_r == ST_HOLD && hold_done;
	endsequence

	sequence brownout_s;
		running && vdm_fail && !sw_por;
	endsequence

	port_reset_a: assert property (sys_reset_out |-> port_latch_out == SMR_PORT_LATCH_RST)
		else $error("port latches not forced in reset");
	reset_halt_a: assert property (sys_reset_out |-> !cpu_run_out && clk_sel_int_out)
		else $error("core running or clock not internal in reset");
	supply_wait_a: assert property (state_r == ST_SUPPLY |-> sys_reset_out)
		else $error("reset released before supply good");
	brownout_a: assert property (brownout_s |=> sys_reset_out && rst_pin_oe_out)
		else $error("supply fault did not hold reset");
	pin_flag_a: assert property (hold_exit_s ##0 pin_cause_r |=> flags_r.pin)
		else $error("pin reset flag not set on exit");
	mcd_flag_a: assert property (hold_exit_s ##0 mcd_cause_r |=> flags_r.lost_clock_detector)
		else $error("clock loss flag not set on exit");
	wdt_gap_a: assert property (wdt_tick_out |=> (!wdt_tick_out)[*8])
		else $error("watchdog ticks too close");
	mon_por_a: assert property (por_exit_s |-> vdm_en_r)
		else $error("monitor off after power-on reset");

endmodule

`default_nettype wire

// ==== tb/tb_smr_top.sv ====
/*
 * Self-checking bench for smr_top: power-up, power control flags, stop mode,
 * each reset source and the reset-source flags.
 * Assumes the design's own assertions sit in its files and a 100 MHz clock.
 */
`default_nettype none

module tb_smr_top
	import smr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int POR = 20;
	localparam int LOST_CLOCK_DETECTOR = 50;
	logic clk_sys_in = 0, rst_in = 1, sfr_wr_in = 0, sfr_rd_in = 0;
	logic supply_ok_in = 0, ext_rst_n_in = 1, irq_wake_in = 0, wdt_disable_in = 0;
	logic tick_en = 1;
	logic [7:0] sfr_addr_in = 0, sfr_wdata_in = 0, sfr_rdata_out, port_latch_out, rv;
	logic rst_pin_out, rst_pin_oe_out, sys_reset_out, cpu_run_out, int_osc_run_out;
	logic periph_run_out, idle_out, pc_load_out, clk_sel_int_out, wdt_enable_out;
	logic wdt_tick_out, port_od_force_out, pullup_en_out;
	logic [15:0] pc_vector_out;
	int bad_count = 0, compares = 0, n;

	smr_top #(.POR_CYC(POR), .MCD_CYC(LOST_CLOCK_DETECTOR)) dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
		.sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
		.supply_ok_in(supply_ok_in), .ext_rst_n_in(ext_rst_n_in),
		.core_tick_in(tick_en), .irq_wake_in(irq_wake_in),
		.wdt_disable_in(wdt_disable_in), .rst_pin_out(rst_pin_out),
		.rst_pin_oe_out(rst_pin_oe_out), .sys_reset_out(sys_reset_out),
		.cpu_run_out(cpu_run_out), .int_osc_run_out(int_osc_run_out),
		.periph_run_out(periph_run_out), .idle_out(idle_out), .pc_load_out(pc_load_out),
		.pc_vector_out(pc_vector_out), .clk_sel_int_out(clk_sel_int_out),
		.wdt_enable_out(wdt_enable_out), .wdt_tick_out(wdt_tick_out),
		.port_latch_out(port_latch_out), .port_od_force_out(port_od_force_out),
		.pullup_en_out(pullup_en_out));

	always #5 clk_sys_in = ~clk_sys_in;

	// =====================================================
	// shared tasks
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		sfr_addr_in <= a;
		sfr_wdata_in <= d;
		sfr_wr_in <= 1;
		@(posedge clk_sys_in);
		sfr_wr_in <= 0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys_in);
		sfr_addr_in <= a;
		sfr_rd_in <= 1;
		@(posedge clk_sys_in);
		sfr_rd_in <= 0;
		#1 rv = sfr_rdata_out;
	endtask

	// write, then read in the very next cycle
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		sfr_addr_in <= a;
		sfr_wdata_in <= d;
		sfr_wr_in <= 1;
		@(posedge clk_sys_in);
		sfr_wr_in <= 0;
		sfr_rd_in <= 1;
		@(posedge clk_sys_in);
		sfr_rd_in <= 0;
		#1 rv = sfr_rdata_out;
	endtask

	// bounded wait for the core to leave reset, then one pc load pulse
	task automatic wait_run();
		n = 0;
		while (sys_reset_out !== 0 && n < 400) begin
			@(posedge clk_sys_in);
			#1 n++;
		end
		chk("reset released", n < 400, 1);
		chk("pc load", pc_load_out, 1);
		chk("vector", pc_vector_out, SMR_RESET_VECTOR);
		chk("wdt on", wdt_enable_out, 1);
	endtask

	task automatic print_verdict();
		if (bad_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// =====================================================
	// scenarios
	task automatic t_power_up();
		repeat (16) @(posedge clk_sys_in);
		rst_in <= 0;
		repeat (30) @(posedge clk_sys_in);
		#1 chk("held low supply", sys_reset_out, 1);
		chk("pin driven", rst_pin_oe_out, 1);
		chk("latch", port_latch_out, SMR_PORT_LATCH_RST);
		chk("open drain", port_od_force_out, 1);
		chk("pullup", pullup_en_out, 1);
		chk("int osc", clk_sel_int_out, 1);
		chk("cpu halted", cpu_run_out, 0);
		chk("pin level", rst_pin_out, 0);
		@(posedge clk_sys_in);
		supply_ok_in <= 1;
		n = 0;
		@(posedge clk_sys_in);
		#1;
		while (sys_reset_out !== 0 && n < 200) begin
			@(posedge clk_sys_in);
			#1 n++;
		end
		chk("por delay", n >= POR - 2 && n <= POR + 3, 1);
		chk("pullup after", pullup_en_out, 1);
		rd(SMR_RST_SRC_ADDR);
		chk("por flag", rv, 8'h02);
		rd(SMR_PWR_CTRL_ADDR);
		chk("power_control reset", rv, SMR_PWR_CTRL_RST);
		rd(SMR_SUP_MON_ADDR);
		chk("monitor on", rv[SMR_SM_EN_BIT], 1);
		n = 0;
		repeat (36) @(posedge clk_sys_in) #1 n += wdt_tick_out;
		chk("wdt ticks", n, 3);
	endtask

	task automatic t_flags_idle();
		wr_rd(SMR_PWR_CTRL_ADDR, 8'hA9);
		chk("gflags idle", rv, 8'hA9);
		chk("idle cpu", cpu_run_out, 0);
		chk("idle out", idle_out, 1);
		@(posedge clk_sys_in);
		irq_wake_in <= 1;
		@(posedge clk_sys_in);
		irq_wake_in <= 0;
		rd(SMR_PWR_CTRL_ADDR);
		chk("woke", rv, 8'hA8);
		rd(8'h33);
		chk("unmapped", rv, 8'h00);
	endtask

	task automatic t_stop_pin();
		wr(SMR_PWR_CTRL_ADDR, 8'h56);
		chk("stop cpu", cpu_run_out, 0);
		chk("stop osc", int_osc_run_out, 0);
		chk("stop periph", periph_run_out, 0);
		@(posedge clk_sys_in);
		irq_wake_in <= 1;
		repeat (8) @(posedge clk_sys_in);
		irq_wake_in <= 0;
		rd(SMR_PWR_CTRL_ADDR);
		chk("stop reads 0", rv, 8'h54);
		chk("still stopped", cpu_run_out, 0);
		@(posedge clk_sys_in);
		ext_rst_n_in <= 0;
		repeat (3) @(posedge clk_sys_in);
		#1 chk("pin rst", sys_reset_out, 1);
		chk("pin not driven", rst_pin_oe_out, 0);
		@(posedge clk_sys_in);
		ext_rst_n_in <= 1;
		wait_run();
		chk("osc back", int_osc_run_out, 1);
		rd(SMR_RST_SRC_ADDR);
		chk("pin flag", rv, 8'h01);
		rd(SMR_PWR_CTRL_ADDR);
		chk("power_control cleared", rv, 8'h00);
		@(posedge clk_sys_in);
		wdt_disable_in <= 1;
		@(posedge clk_sys_in);
		wdt_disable_in <= 0;
		repeat (2) @(posedge clk_sys_in);
		#1 chk("wdt off", wdt_enable_out, 0);
	endtask

	task automatic t_mcd_stop();
		wr(SMR_RST_SRC_ADDR, 8'h04);
		wr(SMR_PWR_CTRL_ADDR, 8'h02);
		@(posedge clk_sys_in);
		tick_en <= 0;
		n = 0;
		while (sys_reset_out !== 1 && n < LOST_CLOCK_DETECTOR + 20) begin
			@(posedge clk_sys_in);
			#1 n++;
		end
		chk("mcd time", n >= LOST_CLOCK_DETECTOR - 2 && n <= LOST_CLOCK_DETECTOR + 3, 1);
		wait_run();
		@(posedge clk_sys_in);
		tick_en <= 1;
		rd(SMR_RST_SRC_ADDR);
		chk("mcd flag", rv, 8'h04);
	endtask

	task automatic t_sw_por();
		wr(SMR_RST_SRC_ADDR, 8'h01);
		@(posedge clk_sys_in);
		#1 chk("sw por pin", rst_pin_oe_out, 1);
		wait_run();
		rd(SMR_RST_SRC_ADDR);
		chk("sw por flag", rv, 8'h02);
	endtask

	task automatic t_monitor();
		@(posedge clk_sys_in);
		supply_ok_in <= 0;
		repeat (3) @(posedge clk_sys_in);
		#1 chk("brownout", sys_reset_out, 1);
		chk("brownout pin", rst_pin_oe_out, 1);
		repeat (20) @(posedge clk_sys_in);
		#1 chk("held", sys_reset_out, 1);
		@(posedge clk_sys_in);
		supply_ok_in <= 1;
		wait_run();
		rd(SMR_RST_SRC_ADDR);
		chk("por cleared", rv[SMR_RS_POR_BIT], 0);
		wr(SMR_SUP_MON_ADDR, 8'h00);
		wr(SMR_RST_SRC_ADDR, 8'h02);
		chk("select fault", sys_reset_out, 1);
		wait_run();
		rd(SMR_SUP_MON_ADDR);
		chk("monitor kept", rv, 8'h40);
	endtask

	initial begin
		#100us;
		bad_count++;
		print_verdict();
	end

	initial begin
		t_power_up();
		t_flags_idle();
		t_stop_pin();
		t_mcd_stop();
		t_sw_por();
		t_monitor();
		print_verdict();
	end
endmodule

`default_nettype wire
